// ===== diag_status_pkg.sv
// ----------------------------------------------------------------------------
// Behaviour
// (R1) Booster fail flag, power rail bit 1, sets on boost under/overvoltage or ground loss.
// (R2) Booster fail clears only when sent and neither under- nor overvoltage remains.
// (R3) Power rail bit 0 follows the present high-side open-load condition, unlatched.
// (R4) System status bit 7 sets when the last reset came from the watchdog.
// (R5) System status bit 6 sets when the last reset was a power-on reset.
// (R6) Watchdog, power-on, switcher clock and clock count flags clear once sent.
// (R7) System status bit 5 sets whenever the device entered test mode.
// (R8) Test-mode flag clears only after being sent and test mode has been left.
// (R9) System status bit 4 sets when the switcher clock is too low.
// (R10) Three-bit error counter is reset only by power-on reset, never by reading.
// (R11) Serial status bit 2 sets when a frame's serial clock count differs from 16.
// (R12) Serial status bit 1 sets when the command identifier lies in a reserved range.
// (R13) Serial status bit 0 sets when the received command fails its parity check.
// (R14) Reserved and parity flags never set on a wrong-count frame; both clear once sent.
// (R15) Writes to these status registers are ignored; no bit changes by a write.
// (R16) A flag counts as sent only within a complete, valid 16-clock frame.
// ----------------------------------------------------------------------------
package diag_status_pkg;

    // ------------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------------
    localparam logic [7:0] POWER_RAIL_OFS    = 8'h21;
    localparam logic [7:0] SYSTEM_STATUS_OFS = 8'h22;
    localparam logic [7:0] SERIAL_LINK_OFS   = 8'h23;

    // ------------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------------
    localparam int BOOST_FAIL_BIT = 1;
    localparam int OPEN_LOAD_BIT  = 0;
    localparam int WDOG_BIT       = 7;
    localparam int POR_BIT        = 6;
    localparam int TEST_BIT       = 5;
    localparam int SWCLK_BIT      = 4;
    localparam int ERR_CNT_LSB    = 1;
    localparam int SCK_FAIL_BIT   = 2;
    localparam int RSVD_CMD_BIT   = 1;
    localparam int PARITY_BIT     = 0;

    // ------------------------------------------------------------------------
    // Reset values and timing counts
    // ------------------------------------------------------------------------
    localparam logic [7:0] POWER_RAIL_RST    = 8'h00;
    localparam logic [7:0] SYSTEM_STATUS_RST = 8'h02;
    localparam logic [7:0] SERIAL_LINK_RST   = 8'h00;
    localparam logic [2:0] ERR_CNT_RST       = 3'h1;
    localparam logic [4:0] FRAME_SCK_COUNT   = 5'h10;

    // ------------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic boost_uv;
        logic boost_ov;
        logic boost_gnd_loss;
        logic open_load;
    } rail_cond_t;

    typedef struct packed {
        logic watchdog_reset;
        logic power_on_reset;
        logic test_mode;
        logic switcher_clock_low;
        logic error_event;
    } sys_event_t;

    typedef struct packed {
        logic reserved_id;
        logic parity_bad;
    } cmd_check_t;

    typedef enum logic [2:0] {
        SEL_POWER  = 3'b001,
        SEL_SYSTEM = 3'b010,
        SEL_SERIAL = 3'b100
    } reg_sel_t;

endpackage

// ===== diag_status_flag_bank.sv
`timescale 1ns/1ps
module diag_status_flag_bank
    import diag_status_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire rail_cond_t rail_cond,
    input  wire sys_event_t sys_event,
    input  wire logic       chip_select_low,
    input  wire logic       serial_clock,
    input  wire cmd_check_t cmd_check,
    input  wire logic       rd_req,
    input  wire logic [7:0] rd_addr,
    output logic      [7:0] rd_data,
    output logic            rd_valid,
    output logic            frame_accept,
    output logic            frame_reject
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    rail_cond_t rail_s1_r;
    rail_cond_t rail_s2_r;
    logic       cs_s1_r;
    logic       cs_s2_r;
    logic       cs_d_r;
    logic       sck_s1_r;
    logic       sck_s2_r;
    logic       sck_d_r;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rail_s1_r <= '0;
            rail_s2_r <= '0;
            cs_s1_r   <= 1'b1;
            cs_s2_r   <= 1'b1;
            cs_d_r    <= 1'b1;
            sck_s1_r  <= 1'b0;
            sck_s2_r  <= 1'b0;
            sck_d_r   <= 1'b0;
        end else begin
            rail_s1_r <= rail_cond;
            rail_s2_r <= rail_s1_r;
            cs_s1_r   <= chip_select_low;
            cs_s2_r   <= cs_s1_r;
            cs_d_r    <= cs_s2_r;
            sck_s1_r  <= serial_clock;
            sck_s2_r  <= sck_s1_r;
            sck_d_r   <= sck_s2_r;
        end
    end

    // ------------------------------------------------------------------------
    // Frame clock count
    // ------------------------------------------------------------------------
    // The serial clock is sampled, so it must stay well below a quarter of clock.
    logic       frame_start;
    logic       frame_end;
    logic       sck_rise;
    logic       frame_good;
    logic       frame_bad;
    logic [4:0] sck_cnt_r;

    assign frame_start = cs_d_r & ~cs_s2_r;
    assign frame_end   = ~cs_d_r & cs_s2_r;
    assign sck_rise    = ~sck_d_r & sck_s2_r & ~cs_s2_r;
    assign frame_good  = frame_end & (sck_cnt_r == FRAME_SCK_COUNT);  // R16
    assign frame_bad   = frame_end & (sck_cnt_r != FRAME_SCK_COUNT);  // R11

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sck_cnt_r <= '0;
        end else if (frame_start) begin
            sck_cnt_r <= '0;
        end else if (sck_rise && sck_cnt_r != 5'h1f) begin
            sck_cnt_r <= sck_cnt_r + 5'h01;
        end
    end

    // ------------------------------------------------------------------------
    // Transmit tracking
    // ------------------------------------------------------------------------
    // Only bits captured into the shifted word are cleared, so an event that
    // arrives after the capture survives until the next read.
    reg_sel_t   tx_sel_r;
    logic [7:0] tx_mask_r;
    logic       tx_busy_r;
    logic [7:0] clr_power;
    logic [7:0] clr_system;
    logic [7:0] clr_serial;
    logic [7:0] read_value;
    reg_sel_t   read_sel;

    assign clr_power  = (frame_good && tx_busy_r && tx_sel_r == SEL_POWER)  ? tx_mask_r : 8'h00;  // R16
    assign clr_system = (frame_good && tx_busy_r && tx_sel_r == SEL_SYSTEM) ? tx_mask_r : 8'h00;  // R16
    assign clr_serial = (frame_good && tx_busy_r && tx_sel_r == SEL_SERIAL) ? tx_mask_r : 8'h00;  // R16

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tx_sel_r  <= SEL_POWER;
            tx_mask_r <= 8'h00;
            tx_busy_r <= 1'b0;
        end else if (rd_req) begin
            tx_sel_r  <= read_sel;
            tx_mask_r <= read_value;
            tx_busy_r <= 1'b1;
        end else if (frame_end) begin
            tx_mask_r <= 8'h00;
            tx_busy_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Power rail flags
    // ------------------------------------------------------------------------
    logic boost_fail_r;
    logic boost_set;
    logic boost_clr;
    logic open_load_r;

    assign boost_set = rail_s2_r.boost_uv | rail_s2_r.boost_ov | rail_s2_r.boost_gnd_loss;  // R1
    assign boost_clr = clr_power[BOOST_FAIL_BIT] & ~rail_s2_r.boost_uv & ~rail_s2_r.boost_ov;  // R2

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            boost_fail_r <= POWER_RAIL_RST[BOOST_FAIL_BIT];
            open_load_r  <= POWER_RAIL_RST[OPEN_LOAD_BIT];
        end else begin
            boost_fail_r <= boost_set | (boost_fail_r & ~boost_clr);  // R1 R2
            open_load_r  <= rail_s2_r.open_load;  // R3
        end
    end

    // ------------------------------------------------------------------------
    // System status flags
    // ------------------------------------------------------------------------
    logic       wdog_r;
    logic       por_r;
    logic       test_r;
    logic       swclk_r;
    logic [2:0] err_cnt_r;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wdog_r  <= SYSTEM_STATUS_RST[WDOG_BIT];
            por_r   <= SYSTEM_STATUS_RST[POR_BIT];
            test_r  <= SYSTEM_STATUS_RST[TEST_BIT];
            swclk_r <= SYSTEM_STATUS_RST[SWCLK_BIT];
        end else begin
            wdog_r  <= sys_event.watchdog_reset | (wdog_r & ~clr_system[WDOG_BIT]);  // R4 R6
            por_r   <= sys_event.power_on_reset | (por_r & ~clr_system[POR_BIT]);  // R5 R6
            test_r  <= sys_event.test_mode | (test_r & ~clr_system[TEST_BIT]);  // R7 R8
            swclk_r <= sys_event.switcher_clock_low | (swclk_r & ~clr_system[SWCLK_BIT]);  // R9 R6
        end
    end

    // Counter saturates so a burst of errors cannot wrap back to a small value.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            err_cnt_r <= ERR_CNT_RST;  // R10
        end else if (sys_event.error_event && err_cnt_r != 3'h7) begin
            err_cnt_r <= err_cnt_r + 3'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Serial link flags
    // ------------------------------------------------------------------------
    logic sck_fail_r;
    logic rsvd_cmd_r;
    logic parity_r;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sck_fail_r <= SERIAL_LINK_RST[SCK_FAIL_BIT];
            rsvd_cmd_r <= SERIAL_LINK_RST[RSVD_CMD_BIT];
            parity_r   <= SERIAL_LINK_RST[PARITY_BIT];
        end else begin
            sck_fail_r <= frame_bad | (sck_fail_r & ~clr_serial[SCK_FAIL_BIT]);  // R11 R6
            rsvd_cmd_r <= (frame_good & cmd_check.reserved_id)
                          | (rsvd_cmd_r & ~clr_serial[RSVD_CMD_BIT]);  // R12 R14
            parity_r   <= (frame_good & cmd_check.parity_bad)
                          | (parity_r & ~clr_serial[PARITY_BIT]);  // R13 R14
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    // There is no write path at all: write frames never reach these flags. R15
    always_comb begin
        read_value = 8'h00;
        read_sel   = SEL_POWER;
        unique case (rd_addr)
            POWER_RAIL_OFS: begin
                read_value[BOOST_FAIL_BIT] = boost_fail_r;
                read_value[OPEN_LOAD_BIT]  = open_load_r;
            end
            SYSTEM_STATUS_OFS: begin
                read_sel                              = SEL_SYSTEM;
                read_value[WDOG_BIT]                  = wdog_r;
                read_value[POR_BIT]                   = por_r;
                read_value[TEST_BIT]                  = test_r;
                read_value[SWCLK_BIT]                 = swclk_r;
                read_value[ERR_CNT_LSB+2:ERR_CNT_LSB] = err_cnt_r;
            end
            SERIAL_LINK_OFS: begin
                read_sel                 = SEL_SERIAL;
                read_value[SCK_FAIL_BIT] = sck_fail_r;
                read_value[RSVD_CMD_BIT] = rsvd_cmd_r;
                read_value[PARITY_BIT]   = parity_r;
            end
            default: begin
                read_value = 8'h00;
                read_sel   = SEL_POWER;
            end
        endcase
    end

    // Error counter bits do enter the clear mask, but err_cnt_r never uses it.
    logic [7:0] rd_data_r;
    logic       rd_valid_r;
    logic       frame_accept_r;
    logic       frame_reject_r;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_data_r      <= 8'h00;
            rd_valid_r     <= 1'b0;
            frame_accept_r <= 1'b0;
            frame_reject_r <= 1'b0;
        end else begin
            rd_valid_r     <= rd_req;
            frame_accept_r <= frame_good;
            frame_reject_r <= frame_bad;
            if (rd_req) begin
                rd_data_r <= read_value;
            end
        end
    end

    assign rd_data      = rd_data_r;
    assign rd_valid     = rd_valid_r;
    assign frame_accept = frame_accept_r;
    assign frame_reject = frame_reject_r;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    sequence s_boost_out_of_window;
        rail_s2_r.boost_uv || rail_s2_r.boost_ov;
    endsequence

    sequence s_bad_frame;
        frame_bad;
    endsequence

    a_boost_set_on_fault: assert property (@(posedge clock) disable iff (!nrst)  // R1
        s_boost_out_of_window |=> boost_fail_r)
        else $error("booster fail flag not set by out-of-window voltage");

    a_boost_held_in_fault: assert property (@(posedge clock) disable iff (!nrst)  // R2
        boost_fail_r and s_boost_out_of_window |=> boost_fail_r)
        else $error("booster fail flag cleared while voltage still out of window");

    a_open_load_live: assert property (@(posedge clock) disable iff (!nrst)  // R3
        ##1 open_load_r == $past(rail_s2_r.open_load))
        else $error("open load bit does not follow its condition");

    a_wdog_clear_sent: assert property (@(posedge clock) disable iff (!nrst)  // R6
        clr_system[WDOG_BIT] && !sys_event.watchdog_reset |=> !wdog_r)
        else $error("watchdog flag not cleared after transmission");

    a_test_held_active: assert property (@(posedge clock) disable iff (!nrst)  // R8
        clr_system[TEST_BIT] && sys_event.test_mode |=> test_r)
        else $error("test mode flag cleared while still in test mode");

    a_err_cnt_monotonic: assert property (@(posedge clock) disable iff (!nrst)  // R10
        ##1 err_cnt_r >= $past(err_cnt_r))
        else $error("error counter decreased without power-on reset");

    a_sck_fail_set: assert property (@(posedge clock) disable iff (!nrst)  // R11
        s_bad_frame |=> sck_fail_r && frame_reject)
        else $error("clock count failure not flagged");

    a_bad_frame_no_id: assert property (@(posedge clock) disable iff (!nrst)  // R14
        s_bad_frame and !rsvd_cmd_r and !parity_r |=> !rsvd_cmd_r && !parity_r)
        else $error("command check flag set on a wrong-count frame");

    a_clear_needs_good: assert property (@(posedge clock) disable iff (!nrst)  // R16
        (clr_power | clr_system | clr_serial) != 8'h00 |-> sck_cnt_r == FRAME_SCK_COUNT)
        else $error("flag cleared by a frame without 16 clocks");

    a_read_data_match: assert property (@(posedge clock) disable iff (!nrst)  // R15
        rd_req |=> rd_valid && rd_data == $past(read_value))
        else $error("read data does not match register contents");

    a_boost_clear_sent: assert property (@(posedge clock) disable iff (!nrst)  // R2
        clr_power[BOOST_FAIL_BIT] && !boost_set |=> !boost_fail_r)
        else $error("booster fail flag not cleared after transmission");

    a_wdog_set_event: assert property (@(posedge clock) disable iff (!nrst)  // R4
        sys_event.watchdog_reset |=> wdog_r)
        else $error("watchdog flag not set by its event");

    a_por_set_event: assert property (@(posedge clock) disable iff (!nrst)  // R5
        sys_event.power_on_reset |=> por_r)
        else $error("power-on flag not set by its event");

    a_por_clear_sent: assert property (@(posedge clock) disable iff (!nrst)  // R6
        clr_system[POR_BIT] && !sys_event.power_on_reset |=> !por_r)
        else $error("power-on flag not cleared after transmission");

    a_test_set_event: assert property (@(posedge clock) disable iff (!nrst)  // R7
        sys_event.test_mode |=> test_r)
        else $error("test mode flag not set in test mode");

    a_test_clear_left: assert property (@(posedge clock) disable iff (!nrst)  // R8
        clr_system[TEST_BIT] && !sys_event.test_mode |=> !test_r)
        else $error("test mode flag not cleared after leaving test mode");

    a_swclk_set_event: assert property (@(posedge clock) disable iff (!nrst)  // R9
        sys_event.switcher_clock_low |=> swclk_r)
        else $error("switcher clock flag not set by a slow clock");

    a_swclk_clear_sent: assert property (@(posedge clock) disable iff (!nrst)  // R6
        clr_system[SWCLK_BIT] && !sys_event.switcher_clock_low |=> !swclk_r)
        else $error("switcher clock flag not cleared after transmission");

    a_err_cnt_step: assert property (@(posedge clock) disable iff (!nrst)  // R10
        sys_event.error_event && err_cnt_r != 3'h7 |=> err_cnt_r == $past(err_cnt_r) + 3'h1)
        else $error("error counter did not count an error event");

    a_err_cnt_hold: assert property (@(posedge clock) disable iff (!nrst)  // R10
        !sys_event.error_event |=> $stable(err_cnt_r))
        else $error("error counter changed without an error event");

    a_rsvd_set_good: assert property (@(posedge clock) disable iff (!nrst)  // R12
        frame_good && cmd_check.reserved_id |=> rsvd_cmd_r)
        else $error("reserved command flag not set on a good frame");

    a_parity_set_good: assert property (@(posedge clock) disable iff (!nrst)  // R13
        frame_good && cmd_check.parity_bad |=> parity_r)
        else $error("parity flag not set on a good frame");

    a_rsvd_clear_sent: assert property (@(posedge clock) disable iff (!nrst)  // R14
        clr_serial[RSVD_CMD_BIT] && !cmd_check.reserved_id |=> !rsvd_cmd_r)
        else $error("reserved command flag not cleared after transmission");

endmodule

// ===== serial_master_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Serial master model
// ----------------------------------------------------------------------------
module serial_master_model
    import diag_status_pkg::*;
(
    input  wire logic  clock,
    output logic       chip_select_low,
    output logic       serial_clock,
    output logic       rd_req,
    output logic [7:0] rd_addr
);
    // The serial clock stands low between frames, as a real master leaves it.
    initial begin
        chip_select_low = 1'b1;
        serial_clock    = 1'b0;
        rd_req          = 1'b0;
        rd_addr         = 8'hff;
    end

    // Each clock phase lasts four core cycles so the synchroniser never misses one.
    task automatic frame(input int edges, input logic [7:0] addr);
        @(posedge clock) #1 chip_select_low = 1'b0;
        repeat (5) @(posedge clock);
        #1 rd_req = 1'b1;
        rd_addr = addr;
        @(posedge clock) #1 rd_req = 1'b0;
        rd_addr = ~addr;
        for (int i = 0; i < edges; i++) begin
            repeat (4) @(posedge clock);
            #1 serial_clock = 1'b1;
            repeat (4) @(posedge clock);
            #1 serial_clock = 1'b0;
        end
        repeat (4) @(posedge clock);
        #1 chip_select_low = 1'b1;
        repeat (8) @(posedge clock);
    endtask
endmodule

// ===== tb_diag_status_flag_bank.sv
`timescale 1ns/1ps
module tb_diag_status_flag_bank
    import diag_status_pkg::*;
;
    logic       clock;
    logic       nrst;
    rail_cond_t rail_cond;
    sys_event_t sys_event;
    cmd_check_t cmd_check;
    logic       chip_select_low;
    logic       serial_clock;
    logic       rd_req;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       frame_accept;
    logic       frame_reject;
    logic [7:0] exp_q[$];
    int         fail_count;
    int         tests_run;
    int         accept_n;
    int         reject_n;
    int         frames_n;
    int         cnt;
    int         n;

    // ------------------------------------------------------------------------
    // Clock, instances
    // ------------------------------------------------------------------------
    initial clock = 1'b0;
    always #5 clock = ~clock;

    diag_status_flag_bank i_dut (
        .clock           (clock),
        .nrst            (nrst),
        .rail_cond       (rail_cond),
        .sys_event       (sys_event),
        .chip_select_low (chip_select_low),
        .serial_clock    (serial_clock),
        .cmd_check       (cmd_check),
        .rd_req          (rd_req),
        .rd_addr         (rd_addr),
        .rd_data         (rd_data),
        .rd_valid        (rd_valid),
        .frame_accept    (frame_accept),
        .frame_reject    (frame_reject)
    );

    serial_master_model i_master (
        .clock           (clock),
        .chip_select_low (chip_select_low),
        .serial_clock    (serial_clock),
        .rd_req          (rd_req),
        .rd_addr         (rd_addr)
    );

    // ------------------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask

    task automatic results();
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Sampled on the falling edge so registered outputs have settled.
    always @(negedge clock) begin
        if (frame_accept === 1'b1) accept_n++;
        if (frame_reject === 1'b1) reject_n++;
        if (rd_valid === 1'b1) check(rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
    end

    initial begin
        #200000;
        fail_count++;
        results();
    end

    // ------------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------------
    task automatic rd_frame(input int edges, input logic [7:0] addr, input logic [7:0] want);
        exp_q.push_back(want);
        frames_n++;
        i_master.frame(edges, addr);
    endtask

    task automatic pulse(input logic [4:0] v);
        @(posedge clock) #1 sys_event = sys_event | v;
        @(posedge clock) #1 sys_event = sys_event & 5'h04;
    endtask

    task automatic rail(input logic [3:0] v);
        @(posedge clock) #1 rail_cond = v;
        repeat (6) @(posedge clock);
    endtask

    initial begin
        nrst = 1'b0;
        rail_cond = '0;
        sys_event = '0;
        cmd_check = '0;
        fail_count = 0;
        tests_run = 0;
        accept_n = 0;
        reject_n = 0;
        frames_n = 0;
        cnt = 1;
        n = $urandom(32'h26d6);
        repeat (8) @(posedge clock);
        #1 nrst = 1'b1;
        rd_frame(16, 8'h21, 8'h00);
        rd_frame(16, 8'h22, 8'h02);
        rd_frame(16, 8'h23, 8'h00);
        rd_frame(16, 8'h40 + 8'($urandom_range(0, 31)), 8'h00);
        @(posedge clock) #1 sys_event.test_mode = 1'b1;
        pulse(5'h1b);
        cnt = 2;
        rd_frame(16, 8'h22, 8'hf4);
        rd_frame(16, 8'h22, 8'h24);
        @(posedge clock) #1 sys_event.test_mode = 1'b0;
        rd_frame(16, 8'h22, 8'h24);
        rd_frame(16, 8'h22, 8'h04);
        n = $urandom_range(1, 8);
        for (int i = 0; i < n; i++) pulse(5'h01);
        cnt = (cnt + n > 7) ? 7 : cnt + n;
        pulse(5'h02);
        cmd_check = 2'b11;
        rd_frame(15, 8'h22, 8'h10 | 8'(cnt << 1));
        cmd_check = 2'b00;
        rd_frame(16, 8'h23, 8'h04);
        rd_frame(16, 8'h22, 8'h10 | 8'(cnt << 1));
        cmd_check = 2'b10;
        rd_frame(16, 8'h23, 8'h00);
        cmd_check = 2'b01;
        rd_frame(16, 8'h23, 8'h02);
        cmd_check = 2'b00;
        rd_frame(16, 8'h23, 8'h01);
        rd_frame(16, 8'h23, 8'h00);
        rail(4'b0101);
        rd_frame(16, 8'h21, 8'h03);
        rail(4'b0001);
        rd_frame(16, 8'h21, 8'h03);
        rd_frame(16, 8'h21, 8'h01);
        rail(4'b0010);
        rail(4'b0000);
        rd_frame(16, 8'h21, 8'h02);
        rd_frame(16, 8'h21, 8'h00);
        rd_frame(16, 8'h22, 8'(cnt << 1));
        @(posedge clock) #1 nrst = 1'b0;
        repeat (2) @(posedge clock);
        #1 nrst = 1'b1;
        rd_frame(16, 8'h22, 8'h02);
        check(8'(reject_n), 8'h01);
        check(8'(accept_n), 8'(frames_n - 1));
        check(8'(exp_q.size()), 8'h00);
        results();
    end
endmodule
